// File: verilog/pcfsg_unit.sv
// One generator unit: source selection, clock and frame sync paths.
// Assumes source inputs are levels synchronous to the core clock.
module pcfsg_unit (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] fs_ctl,
    input  wire logic [31:0] ck_ctl,
    input  wire logic [15:0] pw_half,
    input  wire logic [3:0]  sync_bits,
    input  wire logic        osc_in,
    input  wire logic        ext_in,
    input  wire logic        periph_in,
    input  wire logic        fs_in,
    input  wire logic        misc_in,
    input  wire logic        ext_fs,
    output logic             clk_out,
    output logic             fs_out
);
    logic [19:0] fs_divisor;
    logic [19:0] clk_divisor;
    logic [19:0] fs_phase;
    logic        fs_gen_enable;
    logic        clk_gen_enable;
    logic        ck_src;
    logic        fs_src;
    logic        ck_src_d;
    logic        fs_src_d;
    logic        misc_d;
    logic        ext_fs_d;
    logic        ck_tick;
    logic        fs_tick;
    logic        ext_fs_rise;
    logic        bypass_fs;
    logic        bypass_ck;
    logic        ck_wave;
    logic        fs_wave;
    logic        strobe_pulse;
    logic        strobe_armed;
    logic [19:0] ck_high;

    assign fs_divisor     = fs_ctl[19:0];
    assign clk_divisor    = ck_ctl[19:0];
    assign fs_phase       = {fs_ctl[29:20], ck_ctl[29:20]};
    assign fs_gen_enable  = fs_ctl[pcfsg_pkg::FS_EN_BIT];
    assign clk_gen_enable = fs_ctl[pcfsg_pkg::CLK_EN_BIT];
    assign bypass_fs      = (fs_divisor < 20'h00002);
    assign bypass_ck      = (clk_divisor < 20'h00002);
    assign ck_high        = {1'b0, clk_divisor[19:1]};

    // Peripheral source overrides the select bit
    always_comb begin
        if (sync_bits[pcfsg_pkg::CK_PERIPH_BIT]) begin
            ck_src = periph_in;
        end else begin
            ck_src = ck_ctl[pcfsg_pkg::CLK_SRC_BIT] ? ext_in : osc_in;
        end
        if (sync_bits[pcfsg_pkg::FS_PERIPH_BIT]) begin
            fs_src = periph_in;
        end else begin
            fs_src = ck_ctl[pcfsg_pkg::FS_SRC_BIT] ? ext_in : osc_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ck_src_d <= 1'b0;
            fs_src_d <= 1'b0;
            misc_d   <= 1'b0;
            ext_fs_d <= 1'b0;
        end else begin
            ck_src_d <= ck_src;
            fs_src_d <= fs_src;
            misc_d   <= misc_in;
            ext_fs_d <= ext_fs;
        end
    end

    assign ck_tick     = ck_src & ~ck_src_d;
    assign fs_tick     = fs_src & ~fs_src_d;
    assign ext_fs_rise = ext_fs & ~ext_fs_d;

    pcfsg_divider #(.DIV_W(20), .PW_W(20)) u_ck (
        .clk     (clk),
        .rst     (rst),
        .enable  (clk_gen_enable & ~bypass_ck),
        .tick    (ck_tick),
        .align   (sync_bits[pcfsg_pkg::CK_ALIGN_BIT] & ext_fs_rise),
        .divisor (clk_divisor),
        .phase   (20'h00000),
        .width   (ck_high),
        .wave    (ck_wave)
    );

    pcfsg_divider #(.DIV_W(20), .PW_W(20)) u_fs (
        .clk     (clk),
        .rst     (rst),
        .enable  (fs_gen_enable & ~bypass_fs),
        .tick    (fs_tick),
        .align   (sync_bits[pcfsg_pkg::FS_ALIGN_BIT] & ext_fs_rise),
        .divisor (fs_divisor),
        .phase   (fs_phase),
        .width   ({4'h0, pw_half}),
        .wave    (fs_wave)
    );

    // One-shot armed at frame start; a new frame wins over the clearing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_armed <= 1'b0;
        end else if (fs_in & ~fs_src_d & fs_src) begin
            strobe_armed <= 1'b1;
        end else if (misc_in & ~misc_d) begin
            strobe_armed <= 1'b0;
        end
    end

    // Misc edges bound the pulse, so it lasts one misc period unless re-armed before the next misc edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_pulse <= 1'b0;
        end else if (misc_in & ~misc_d) begin
            strobe_pulse <= strobe_armed;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out <= 1'b0;
            fs_out  <= 1'b0;
        end else begin
            clk_out <= !clk_gen_enable ? 1'b0 : (bypass_ck ? ck_src : ck_wave);
            if (!fs_gen_enable) begin
                fs_out <= 1'b0;
            end else if (!bypass_fs) begin
                fs_out <= fs_wave;
            end else if (pw_half[pcfsg_pkg::STROBE_BIT]) begin
                fs_out <= strobe_pulse ^ pw_half[pcfsg_pkg::INVERT_BIT];
            end else begin
                fs_out <= fs_in ^ pw_half[pcfsg_pkg::INVERT_BIT];
            end
        end
    end
endmodule

// File: inc/pcfsg_pkg.sv
// Constants shared by the precision clock and frame sync generator.
// Assumes a single core clock; all source clocks arrive as sampled levels.
package pcfsg_pkg;
    localparam int          UNITS         = 4;
    localparam int          DIV_W         = 20;
    localparam int          PW_W          = 16;
    localparam int          ADDR_W        = 4;
    // Register indices, word addresses on the plain port
    localparam logic [3:0]  FSCTL_A       = 4'h0;
    localparam logic [3:0]  CKCTL_A       = 4'h1;
    localparam logic [3:0]  FSCTL_B       = 4'h2;
    localparam logic [3:0]  CKCTL_B       = 4'h3;
    localparam logic [3:0]  FSCTL_C       = 4'h4;
    localparam logic [3:0]  CKCTL_C       = 4'h5;
    localparam logic [3:0]  FSCTL_D       = 4'h6;
    localparam logic [3:0]  CKCTL_D       = 4'h7;
    localparam logic [3:0]  PW_AB_ADDR    = 4'h8;
    localparam logic [3:0]  PW_CD_ADDR    = 4'h9;
    localparam logic [3:0]  SYNC_AB_ADDR  = 4'hA;
    localparam logic [3:0]  SYNC_CD_ADDR  = 4'hB;
    localparam logic [3:0]  STATUS_ADDR   = 4'hC;
    // Field positions, control registers
    localparam int          DIV_LSB       = 0;
    localparam int          PHASE_LSB     = 20;
    localparam int          PHASE_W       = 10;
    localparam int          FS_EN_BIT     = 30;
    localparam int          CLK_EN_BIT    = 31;
    localparam int          FS_SRC_BIT    = 30;
    localparam int          CLK_SRC_BIT   = 31;
    // Per half-word fields of pulse width and sync registers
    localparam int          HALF_OFS      = 16;
    localparam int          STROBE_BIT    = 0;
    localparam int          INVERT_BIT    = 1;
    localparam int          FS_ALIGN_BIT  = 0;
    localparam int          CK_ALIGN_BIT  = 1;
    localparam int          CK_PERIPH_BIT = 2;
    localparam int          FS_PERIPH_BIT = 3;
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// File: verilog/pcfsg_divider.sv
// Programmable divider with phase and pulse width, one per output.
// Assumes tick is a one-cycle pulse per source clock rising edge.
module pcfsg_divider #(
    parameter int DIV_W = 20,
    parameter int PW_W  = 20
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic             tick,
    input  wire logic             align,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic [DIV_W-1:0] phase,
    input  wire logic [PW_W-1:0]  width,
    output logic                  wave
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] pos;

    // Counter restarts on align so the output lines up with the external frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (!enable || align) begin
            count <= '0;
        end else if (tick) begin
            count <= (count >= divisor - 1'b1) ? '0 : count + 1'b1;
        end
    end

    // Position in period after phase offset, wrapped into the period
    always_comb begin
        if (count >= phase % divisor) begin
            pos = count - phase % divisor;
        end else begin
            pos = DIV_W'(count + divisor - phase % divisor);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wave <= 1'b0;
        end else if (!enable) begin
            wave <= 1'b0;
        end else begin
            wave <= (pos < DIV_W'(width));
        end
    end
endmodule

// File: verilog/pcfsg_top.sv
// Four-unit precision clock and frame sync generator with register port.
// Assumes a plain register port: read data appears one cycle after strobe.
//
// Functional notes
// - Four identical units, each one clock and one frame sync output.
// - Frame sync divisor bits 19-0; above one normal, else bypass.
// - Phase is upper ten bits from first, lower from second register.
// - Bit 30 of first register enables frame sync generation.
// - Bit 31 of first register enables clock generation.
// - Clock divisor bits 19-0; zero or one passes source through.
// - Bit 30 of second register picks oscillator or external frame sync source.
// - One-shot strobe repeats at the frame sync period.
// - Bit 31 of second register picks oscillator or external clock source.
// - Normal frame sync stays high for pulse width source periods.
// - Pulse width low half for first unit, high half for second.
// - Bypass without strobe passes frame sync input, optionally inverted.
// - Bypass with strobe emits one misc-period pulse each frame.
// - Invert bit makes bypass frame sync active low.
// - Bypass ignores the remaining pulse width bits.
// - Frame sync align bit restarts frame sync on external frame sync.
// - Clock align bit restarts clock on external frame sync.
// - Clock peripheral bit feeds clock from peripheral clock.
// - Frame sync peripheral bit feeds frame sync from peripheral clock.
module pcfsg_top (
    input  wire logic                          CORE_CLK,
    input  wire logic                          RST,
    input  wire logic [pcfsg_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [31:0]                   WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [31:0]                   RDATA,
    input  wire logic                          OSC_IN,
    input  wire logic                          PERIPH_CLK,
    input  wire logic [3:0]                    EXT_IN,
    input  wire logic [3:0]                    FS_IN,
    input  wire logic [3:0]                    MISC_IN,
    input  wire logic                          EXT_FS,
    output logic      [3:0]                    CLK_OUT,
    output logic      [3:0]                    FS_OUT
);
    logic [31:0] fs_ctl [4];
    logic [31:0] ck_ctl [4];
    logic [31:0] pw_ab;
    logic [31:0] pw_cd;
    logic [31:0] sync_ab;
    logic [31:0] sync_cd;
    logic [3:0]  clk_w;
    logic [3:0]  fs_w;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 4; i++) begin
                fs_ctl[i] <= pcfsg_pkg::REG_RESET;
                ck_ctl[i] <= pcfsg_pkg::REG_RESET;
            end
            pw_ab   <= pcfsg_pkg::REG_RESET;
            pw_cd   <= pcfsg_pkg::REG_RESET;
            sync_ab <= pcfsg_pkg::REG_RESET;
            sync_cd <= pcfsg_pkg::REG_RESET;
        end else if (WR) begin
            if (ADDR < pcfsg_pkg::PW_AB_ADDR) begin
                if (ADDR[0]) begin
                    ck_ctl[ADDR[2:1]] <= WDATA;
                end else begin
                    fs_ctl[ADDR[2:1]] <= WDATA;
                end
            end
            unique case (ADDR)
                pcfsg_pkg::PW_AB_ADDR:   pw_ab   <= WDATA;
                pcfsg_pkg::PW_CD_ADDR:   pw_cd   <= WDATA;
                pcfsg_pkg::SYNC_AB_ADDR: sync_ab <= WDATA & 32'h000F_000F;
                pcfsg_pkg::SYNC_CD_ADDR: sync_cd <= WDATA & 32'h000F_000F;
                default: ;
            endcase
        end
    end

    // Status word shows the live output levels
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            if (ADDR < pcfsg_pkg::PW_AB_ADDR) begin
                RDATA <= ADDR[0] ? ck_ctl[ADDR[2:1]] : fs_ctl[ADDR[2:1]];
            end else begin
                unique case (ADDR)
                    pcfsg_pkg::PW_AB_ADDR:   RDATA <= pw_ab;
                    pcfsg_pkg::PW_CD_ADDR:   RDATA <= pw_cd;
                    pcfsg_pkg::SYNC_AB_ADDR: RDATA <= sync_ab;
                    pcfsg_pkg::SYNC_CD_ADDR: RDATA <= sync_cd;
                    pcfsg_pkg::STATUS_ADDR:  RDATA <= {24'h000000, fs_w, clk_w};
                    default:                 RDATA <= pcfsg_pkg::UNMAPPED_DATA;
                endcase
            end
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    for (genvar u = 0; u < 4; u++) begin : g_unit
        localparam int H = (u % 2) * pcfsg_pkg::HALF_OFS;
        logic [31:0] pw_reg;
        logic [31:0] sy_reg;
        assign pw_reg = (u < 2) ? pw_ab : pw_cd;
        assign sy_reg = (u < 2) ? sync_ab : sync_cd;
        pcfsg_unit u_unit (
            .clk       (CORE_CLK),
            .rst       (RST),
            .fs_ctl    (fs_ctl[u]),
            .ck_ctl    (ck_ctl[u]),
            .pw_half   (pw_reg[H +: 16]),
            .sync_bits (sy_reg[H +: 4]),
            .osc_in    (OSC_IN),
            .ext_in    (EXT_IN[u]),
            .periph_in (PERIPH_CLK),
            .fs_in     (FS_IN[u]),
            .misc_in   (MISC_IN[u]),
            .ext_fs    (EXT_FS),
            .clk_out   (clk_w[u]),
            .fs_out    (fs_w[u])
        );
    end

    assign CLK_OUT = clk_w;
    assign FS_OUT  = fs_w;
endmodule

// File: verification/pcfsg_chk.sv
// Port-level checker for the four-unit clock and frame sync generator.
// Assumes the plain register port and unit A control shadowed from writes.
module pcfsg_chk (
    input wire logic                         CORE_CLK,
    input wire logic                         RST,
    input wire logic [pcfsg_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0]                  WDATA,
    input wire logic                         WR,
    input wire logic                         RD,
    input wire logic [31:0]                  RDATA,
    input wire logic [3:0]                   FS_IN,
    input wire logic [3:0]                   CLK_OUT,
    input wire logic [3:0]                   FS_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic [31:0] fs_ctl;
    logic [31:0] pw_ab;
    logic        plain;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            fs_ctl <= 32'h0000_0000;
        else if (WR && ADDR == pcfsg_pkg::FSCTL_A)
            fs_ctl <= WDATA;
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            pw_ab <= 32'h0000_0000;
        else if (WR && ADDR == pcfsg_pkg::PW_AB_ADDR)
            pw_ab <= WDATA;
    end
    // Bypass with strobe clear; invert judged separately
    assign plain = fs_ctl[30] && fs_ctl[19:0] < 20'h00002 && !pw_ab[0];
    chk_rdata_idle: assert property (!RD |=> RDATA == 32'h0000_0000)
        else $error("read data not zero outside read");
    chk_unmapped_read: assert property (RD && ADDR > pcfsg_pkg::STATUS_ADDR
        |=> RDATA == pcfsg_pkg::UNMAPPED_DATA) else $error("unmapped read not zero");
    chk_ctl_readback: assert property (RD && ADDR == pcfsg_pkg::FSCTL_A
        |=> RDATA == $past(fs_ctl)) else $error("frame control readback wrong");
    chk_sync_mask: assert property (RD && ADDR == pcfsg_pkg::SYNC_AB_ADDR
        |=> (RDATA & 32'hFFF0_FFF0) == 32'h0000_0000) else $error("sync reserved bits set");
    chk_status_word: assert property (RD && ADDR == pcfsg_pkg::STATUS_ADDR
        |=> RDATA == {24'h00_0000, $past(FS_OUT), $past(CLK_OUT)})
        else $error("status word wrong");
    chk_clk_off: assert property ((!fs_ctl[31])[*4] |-> !CLK_OUT[0])
        else $error("clock output active while disabled");
    chk_fs_off: assert property ((!fs_ctl[30])[*4] |-> !FS_OUT[0])
        else $error("frame sync active while disabled");
    chk_bypass_pass: assert property ((plain && !pw_ab[1] && $stable(FS_IN[0]))[*4]
        |-> FS_OUT[0] == FS_IN[0]) else $error("bypass frame sync not passed");
    chk_bypass_invert: assert property ((plain && pw_ab[1] && $stable(FS_IN[0]))[*4]
        |-> FS_OUT[0] == !FS_IN[0]) else $error("bypass frame sync not inverted");
    cover property (RD && ADDR == pcfsg_pkg::STATUS_ADDR);
    cover property ($rose(FS_OUT[0]));
    cover property ($rose(CLK_OUT[1]));
endmodule

bind pcfsg_top pcfsg_chk u_chk (.CORE_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .FS_IN, .CLK_OUT, .FS_OUT);

// File: verification/pcfsg_sink.sv
// Far-side consumer: measures frame sync width and period and clock period.
// Assumes outputs are sampled on the core clock; counts are in core cycles.
module pcfsg_sink (
    input  wire logic clk,
    input  wire logic fs,
    input  wire logic ck,
    output int        fs_high,
    output int        fs_period,
    output int        ck_period
);
    timeunit 1ns;
    timeprecision 1ps;
    int   fs_n;
    int   ck_n;
    int   hi_n;
    logic fs_q;
    logic ck_q;
    always @(posedge clk) begin
        fs_q <= fs;
        ck_q <= ck;
        fs_n <= fs_n + 1;
        ck_n <= ck_n + 1;
        hi_n <= fs ? hi_n + 1 : 0;
        if (fs && !fs_q) begin
            fs_period <= fs_n;
            fs_n <= 1;
        end
        if (!fs && fs_q)
            fs_high <= hi_n;
        if (ck && !ck_q) begin
            ck_period <= ck_n;
            ck_n <= 1;
        end
    end
endmodule

// File: verification/tb.sv
// Register-driven testbench for the clock and frame sync generator.
// Assumes oscillator period 2 cycles, external and peripheral period 4.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CORE_CLK, RST, WR, RD, OSC_IN, PERIPH_CLK, EXT_FS;
    logic [3:0]  ADDR, EXT_IN, FS_IN, MISC_IN, CLK_OUT, FS_OUT;
    logic [31:0] WDATA, RDATA;
    int          mismatches, total_checks, cycles;
    int          fs_hi_a, fs_per_a, ck_per_a, fs_hi_b;
    logic        aligned;
    logic [3:0]  fs_a_hist;
    pcfsg_top u_dut (.CORE_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .OSC_IN,
        .PERIPH_CLK, .EXT_IN, .FS_IN, .MISC_IN, .EXT_FS, .CLK_OUT, .FS_OUT);
    pcfsg_sink u_snk_a (.clk(CORE_CLK), .fs(FS_OUT[0]), .ck(CLK_OUT[0]),
        .fs_high(fs_hi_a), .fs_period(fs_per_a), .ck_period(ck_per_a));
    pcfsg_sink u_snk_b (.clk(CORE_CLK), .fs(FS_OUT[1]), .ck(CLK_OUT[1]),
        .fs_high(fs_hi_b), .fs_period(), .ck_period());
    task automatic tally_and_finish();
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        WR <= 1'b1;
        RD <= 1'b0;
        ADDR <= a;
        WDATA <= d;
        @(posedge CORE_CLK);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        WR <= 1'b0;
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 chk(RDATA === e, "read data");
        @(posedge CORE_CLK);
    endtask
    task automatic idle(input int n);
        WR <= 1'b0;
        repeat (n) @(posedge CORE_CLK);
    endtask
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // Source levels change on core edges, as the design samples them
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        OSC_IN <= ~OSC_IN;
        // Unit B runs two source ticks, four cycles, behind unit A once aligned
        fs_a_hist <= {fs_a_hist[2:0], FS_OUT[0]};
        if (aligned) begin
            chk(FS_OUT[1] === fs_a_hist[3], "frame sync phase");
            chk(CLK_OUT[1] === CLK_OUT[0], "clock alignment");
        end
        if (cycles % 2 == 1) begin
            PERIPH_CLK <= ~PERIPH_CLK;
            EXT_IN <= ~EXT_IN;
            MISC_IN <= ~MISC_IN;
        end
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        {RST, WR, RD, OSC_IN, PERIPH_CLK, EXT_FS, aligned} = 7'b1000000;
        {ADDR, EXT_IN, FS_IN, MISC_IN} = 16'h0000;
        WDATA = 32'h0000_0000;
        repeat (3) @(posedge CORE_CLK);
        RST <= 1'b0;
        for (int i = 0; i < 16; i++) rd_chk(i[3:0], pcfsg_pkg::REG_RESET);
        for (int i = 0; i < 10; i++) wr(i[3:0], {28'h5A0_0000, i[3:0]});
        for (int i = 0; i < 10; i++) rd_chk(i[3:0], {28'h5A0_0000, i[3:0]});
        wr(pcfsg_pkg::SYNC_AB_ADDR, 32'hFFFF_FFFF);
        rd_chk(pcfsg_pkg::SYNC_AB_ADDR, 32'h000F_000F);
        for (int i = 0; i < 12; i++) wr(i[3:0], 32'h0000_0000);
        wr(pcfsg_pkg::PW_AB_ADDR, 32'h0005_0003);
        wr(pcfsg_pkg::CKCTL_A, 32'h0000_0004);
        wr(pcfsg_pkg::CKCTL_B, 32'h0000_0004);
        wr(pcfsg_pkg::FSCTL_A, 32'hC000_0008);
        wr(pcfsg_pkg::FSCTL_B, 32'hC000_0008);
        idle(100);
        chk(fs_per_a === 16 && ck_per_a === 8, "normal periods");
        chk(fs_hi_a === 6, "pulse width unit A");
        chk(fs_hi_b === 10, "pulse width unit B");
        wr(pcfsg_pkg::CKCTL_A, 32'hC000_0004);
        idle(150);
        chk(fs_per_a === 32 && ck_per_a === 16, "external source");
        chk(fs_hi_a === 12, "width on external source");
        wr(pcfsg_pkg::CKCTL_A, 32'h0000_0004);
        wr(pcfsg_pkg::SYNC_AB_ADDR, 32'h0000_000C);
        idle(150);
        chk(fs_per_a === 32 && ck_per_a === 16, "peripheral source");
        wr(pcfsg_pkg::SYNC_AB_ADDR, 32'h0000_0000);
        wr(pcfsg_pkg::PW_AB_ADDR, 32'h0000_0000);
        wr(pcfsg_pkg::FSCTL_A, 32'h4000_0001);
        FS_IN <= 4'h1;
        idle(8);
        chk(FS_OUT[0] === 1'b1, "bypass high");
        FS_IN <= 4'h0;
        idle(8);
        chk(FS_OUT[0] === 1'b0, "bypass low");
        wr(pcfsg_pkg::PW_AB_ADDR, 32'h0000_FFFE);
        idle(8);
        chk(FS_OUT[0] === 1'b1, "bypass inverted");
        wr(pcfsg_pkg::PW_AB_ADDR, 32'h0000_0001);
        wr(pcfsg_pkg::CKCTL_A, 32'h0000_0001);
        wr(pcfsg_pkg::FSCTL_A, 32'hC000_0001);
        FS_IN <= 4'h1;
        idle(2);
        FS_IN <= 4'h0;
        idle(20);
        chk(fs_hi_a === 4, "one-shot lasts one misc period");
        chk(ck_per_a === 2, "clock bypass");
        wr(pcfsg_pkg::FSCTL_A, 32'h0000_0008);
        wr(pcfsg_pkg::FSCTL_B, 32'h0000_0000);
        idle(8);
        rd_chk(pcfsg_pkg::STATUS_ADDR, 32'h0000_0000);
        // Units enabled two ticks apart, so only the align can line them up
        wr(pcfsg_pkg::PW_AB_ADDR, 32'h0003_0003);
        wr(pcfsg_pkg::CKCTL_A, 32'h0000_0004);
        wr(pcfsg_pkg::CKCTL_B, 32'h0020_0004);
        wr(pcfsg_pkg::SYNC_AB_ADDR, 32'h0003_0003);
        wr(pcfsg_pkg::FSCTL_A, 32'hC000_0008);
        idle(3);
        wr(pcfsg_pkg::FSCTL_B, 32'hC000_0008);
        idle(20);
        EXT_FS <= 1'b1;
        idle(2);
        EXT_FS <= 1'b0;
        idle(20);
        aligned <= 1'b1;
        idle(48);
        aligned <= 1'b0;
        tally_and_finish();
    end
endmodule
